// ===== core/drs_params.svh
// constants for the dual rheostat serial command core
`ifndef DRS_PARAMS_SVH
`define DRS_PARAMS_SVH

`define DRS_CMD_MSB 23
`define DRS_CMD_LSB 20
`define DRS_ADR_MSB 19
`define DRS_ADR_LSB 16
`define DRS_FRAME_BITS 24
`define DRS_WIPER_BITS 10
`define DRS_DATA_BITS 16
`define DRS_ADDR_BITS 4
`define DRS_MIDSCALE 10'h200
`define DRS_FULLSCALE 10'h3ff
`define DRS_TOL_ADDR 4'h2
`define DRS_TOL_VALUE 16'h0000
`define DRS_CLK_MHZ 50
`define DRS_SAVE_US 20000
`define DRS_RESTORE_US 1000
`define DRS_READ_US 100
`define DRS_SAVE_CYC (`DRS_SAVE_US * `DRS_CLK_MHZ)
`define DRS_RESTORE_CYC (`DRS_RESTORE_US * `DRS_CLK_MHZ)
`define DRS_READ_CYC (`DRS_READ_US * `DRS_CLK_MHZ)
`define DRS_WAIT_BITS 20
`endif

// ===== core/drs_pkg.sv
// types for the dual rheostat serial command core
package drs_pkg;
    typedef enum logic [3:0] {
        DRS_NOP = 4'h0, DRS_RESTORE = 4'h1, DRS_SAVE = 4'h2, DRS_SAVE_USER = 4'h3,
        DRS_HALVE_ONE = 4'h4, DRS_HALVE_ALL = 4'h5, DRS_DOWN_ONE = 4'h6, DRS_DOWN_ALL = 4'h7,
        DRS_RESTORE_ALL = 4'h8, DRS_READ_STORE = 4'h9, DRS_READ_WIPER = 4'ha, DRS_WRITE = 4'hb,
        DRS_DOUBLE_ONE = 4'hc, DRS_DOUBLE_ALL = 4'hd, DRS_UP_ONE = 4'he, DRS_UP_ALL = 4'hf
    } drs_cmd_t;
    typedef enum logic [2:0] {
        DRS_S_IDLE = 3'h0, DRS_S_LD0 = 3'h1, DRS_S_LD1 = 3'h2, DRS_S_LD2 = 3'h3,
        DRS_S_RDST = 3'h4, DRS_S_WAIT = 3'h5, DRS_S_PRESET = 3'h6
    } drs_state_t;
endpackage

// ===== core/drs_store.sv
// nonvolatile store model: reset stands for the factory contents
`timescale 1ns/100ps
`default_nettype none
module drs_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter logic [WIDTH-1:0] WIPER_INIT = 16'h0000,
    parameter logic [AW-1:0] TOL_ADDR = 4'h0,
    parameter logic [WIDTH-1:0] TOL_INIT = 16'h0000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] rdata_reg;

    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        // locations 0 and 1 are the wiper settings, one holds the tolerance
        localparam logic [WIDTH-1:0] RST_VAL = (i < 2) ? WIPER_INIT :
            (i == int'(TOL_ADDR)) ? TOL_INIT : '0;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_reg[i] <= RST_VAL;
            end else if (we && addr == AW'(i)) begin
                mem_reg[i] <= wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= mem_reg[addr];
        end
    end
    assign rdata = rdata_reg;
endmodule
`default_nettype wire

// ===== core/drs_core.sv
// serial command interpreter for the dual rheostat wiper registers
`timescale 1ns/100ps
`default_nettype none
`include "drs_params.svh"
module drs_core import drs_pkg::*; #(
    parameter int WW = `DRS_WIPER_BITS,
    parameter int DW = `DRS_DATA_BITS,
    parameter int SAVE_CYC = `DRS_SAVE_CYC,
    parameter int RESTORE_CYC = `DRS_RESTORE_CYC,
    parameter int READ_CYC = `DRS_READ_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic preset_pin_n,
    input wire logic wp_n,
    output logic sdo,
    output logic rdy,
    output logic [WW-1:0] wiper0,
    output logic [WW-1:0] wiper1
);
    localparam int FB = `DRS_FRAME_BITS;
    localparam int AWD = `DRS_ADDR_BITS;
    localparam int WTB = `DRS_WAIT_BITS;
    localparam logic [WW-1:0] MID = `DRS_MIDSCALE;
    localparam logic [WW-1:0] FULL = `DRS_FULLSCALE;
    localparam logic [4:0] LAST_BIT = 5'(FB - 1);
    localparam logic [4:0] CNT_DONE = 5'(FB);

    ////////////////////////////////////////////////////////////////////////
    // link side, clocked by the host's serial clock

    logic [FB-1:0] shift_reg;
    logic [FB-1:0] frame_reg;
    logic [4:0] bit_cnt_reg;
    logic frame_tgl_reg;
    logic rb_pend_reg;
    logic [DW-1:0] rb_word_reg;
    logic [FB-1:0] shift_next;
    logic [3:0] shift_cmd;
    logic link_clr_n;

    // rb_word_reg only changes while ready is low, and the host waits for
    // ready before the next frame, so it is stable when sampled here
    // readback spliced
    assign shift_next = (bit_cnt_reg == 5'h00 && rb_pend_reg) ?
        {shift_reg[FB-2:DW], rb_word_reg, sdi} : {shift_reg[FB-2:0], sdi};
    assign shift_cmd = shift_next[`DRS_CMD_MSB:`DRS_CMD_LSB];
    assign link_clr_n = rst_n & ~cs_n;

    // bit counter is cleared by chip select itself, since the serial clock
    // stands still between frames
    always_ff @(posedge sclk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            bit_cnt_reg <= 5'h00;
        end else if (bit_cnt_reg != CNT_DONE) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            frame_reg <= '0;
            frame_tgl_reg <= 1'b0;
            rb_pend_reg <= 1'b0;
        end else if (bit_cnt_reg == LAST_BIT) begin
            frame_reg <= shift_next;
            frame_tgl_reg <= ~frame_tgl_reg;
            rb_pend_reg <= (shift_cmd == DRS_READ_STORE) || (shift_cmd == DRS_READ_WIPER);
        end else if (bit_cnt_reg == 5'h00) begin
            rb_pend_reg <= 1'b0;
        end
    end
    assign sdo = shift_reg[FB-1];

    ////////////////////////////////////////////////////////////////////////
    // synchronisers into clk: cs_n, frame toggle, preset pin, write protect

    localparam logic [3:0] SYNC_INIT = 4'hd;
    logic [3:0] async_in;
    logic [3:0] level;
    assign async_in = {wp_n, preset_pin_n, frame_tgl_reg, cs_n};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        logic [2:0] sync_reg;
        logic lvl_reg;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sync_reg <= {3{SYNC_INIT[i]}};
                lvl_reg <= SYNC_INIT[i];
            end else begin
                sync_reg <= {sync_reg[1:0], async_in[i]};
                lvl_reg <= (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
            end
        end
        assign level[i] = lvl_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode

    drs_state_t state_reg, state_next;
    logic cs_prev_reg;
    logic seen_tgl_reg;
    logic rdy_reg, rdy_next;
    logic [1:0] mask_reg, mask_next;
    logic [WTB-1:0] wait_reg, wait_next;
    logic [WW-1:0] wiper_reg [2];
    logic [DW-1:0] rdata;

    wire cs_rise = level[0] & ~cs_prev_reg;
    wire frame_new = level[1] ^ seen_tgl_reg;
    wire preset_low = ~level[2];
    wire wp = ~level[3];
    wire drs_cmd_t cmd = drs_cmd_t'(frame_reg[`DRS_CMD_MSB:`DRS_CMD_LSB]);
    wire [AWD-1:0] addr = frame_reg[`DRS_ADR_MSB:`DRS_ADR_LSB];
    wire [DW-1:0] data = frame_reg[DW-1:0];
    wire exec = cs_rise & frame_new & (state_reg == DRS_S_IDLE) & ~preset_low;
    wire wiper_cmd = cmd[2] | (cmd == DRS_WRITE);
    wire gang = cmd[2] & cmd[0];
    wire is_save = (cmd == DRS_SAVE) || (cmd == DRS_SAVE_USER);
    // write protect and factory tolerance kept
    wire store_we = exec & is_save & ~wp & (addr != `DRS_TOL_ADDR);
    // save uses 10 bits, user data 16 bits
    wire [DW-1:0] store_wdata = (cmd == DRS_SAVE) ?
        {{(DW - WW){1'b0}}, wiper_reg[addr[0]]} : data;
    wire [AWD-1:0] store_addr = (state_reg == DRS_S_LD0) ? 4'h0 :
        (state_reg == DRS_S_LD1) ? 4'h1 : addr;

    drs_store #(
        .WIDTH(DW),
        .DEPTH(1 << AWD),
        .AW(AWD),
        .WIPER_INIT({{(DW - WW){1'b0}}, MID}),
        .TOL_ADDR(`DRS_TOL_ADDR),
        .TOL_INIT(`DRS_TOL_VALUE)
    ) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .we(store_we),
        .addr(store_addr),
        .wdata(store_wdata),
        .rdata(rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // wiper registers, one per channel

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        wire [WW-1:0] w = wiper_reg[ch];
        wire [WW-1:0] inc = (w == FULL) ? w : w + 10'h001;
        wire [WW-1:0] dec = (w == '0) ? w : w - 10'h001;
        wire [WW-1:0] shl = (w == '0) ? 10'h001 : (w >= MID) ? FULL : {w[WW-2:0], 1'b0};
        wire [WW-1:0] shr = {1'b0, w[WW-1:1]};
        // steps ignore data, by one, by shift
        wire [WW-1:0] op = (cmd == DRS_WRITE) ? data[WW-1:0] :
            cmd[1] ? (cmd[3] ? inc : dec) : (cmd[3] ? shl : shr);
        wire hit = exec & wiper_cmd & ~wp & (gang | (addr[0] == 1'(ch)));
        wire load = mask_reg[ch] & (state_reg == ((ch == 0) ? DRS_S_LD1 : DRS_S_LD2));
        wire [WW-1:0] w_next = preset_low ? MID : load ? rdata[WW-1:0] : hit ? op : w;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                wiper_reg[ch] <= MID;
            end else begin
                wiper_reg[ch] <= w_next;
            end
        end
    end
    assign wiper0 = wiper_reg[0];
    assign wiper1 = wiper_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // sequencer: restores, saves, reads and the ready flag

    always_comb begin
        state_next = state_reg;
        mask_next = mask_reg;
        rdy_next = rdy_reg;
        wait_next = wait_reg;
        case (state_reg)
            DRS_S_IDLE: begin
                if (preset_low) begin
                    state_next = DRS_S_PRESET;
                    rdy_next = 1'b0;
                end else if (exec) begin
                    // ready low for all of these but the single restore and a refused save, with their lengths
                    case (cmd)
                        DRS_RESTORE: begin
                            state_next = DRS_S_LD0;
                            mask_next = addr[0] ? 2'h2 : 2'h1;
                        end
                        DRS_RESTORE_ALL: begin
                            state_next = DRS_S_LD0;
                            mask_next = 2'h3;
                            rdy_next = 1'b0;
                            wait_next = WTB'(RESTORE_CYC - 4);
                        end
                        DRS_SAVE, DRS_SAVE_USER: begin
                            if (store_we) begin
                                state_next = DRS_S_WAIT;
                                rdy_next = 1'b0;
                                wait_next = WTB'(SAVE_CYC - 1);
                            end
                        end
                        DRS_READ_STORE: begin
                            state_next = DRS_S_RDST;
                            rdy_next = 1'b0;
                            wait_next = WTB'(READ_CYC - 2);
                        end
                        DRS_READ_WIPER: begin
                            state_next = DRS_S_WAIT;
                            rdy_next = 1'b0;
                            wait_next = WTB'(READ_CYC - 1);
                        end
                        default: begin
                        end
                    endcase
                end
            end
            DRS_S_LD0: state_next = DRS_S_LD1;
            DRS_S_LD1: state_next = DRS_S_LD2;
            DRS_S_LD2: state_next = rdy_reg ? DRS_S_IDLE : DRS_S_WAIT;
            DRS_S_RDST: state_next = DRS_S_WAIT;
            DRS_S_WAIT: begin
                if (preset_low) begin
                    state_next = DRS_S_PRESET;
                end else if (wait_reg == '0) begin
                    state_next = DRS_S_IDLE;
                    rdy_next = 1'b1;
                end else begin
                    wait_next = wait_reg - 1'b1;
                end
            end
            DRS_S_PRESET: begin
                // stored values load only after the pin returns high
                if (!preset_low) begin
                    state_next = DRS_S_LD0;
                    mask_next = 2'h3;
                    wait_next = WTB'(RESTORE_CYC - 4);
                end
            end
            default: state_next = DRS_S_IDLE;
        endcase
    end

    // power-on starts in the load sequence so both wipers come from the store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= DRS_S_LD0;
            mask_reg <= 2'h3;
            rdy_reg <= 1'b1;
            wait_reg <= '0;
            cs_prev_reg <= 1'b1;
            seen_tgl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mask_reg <= mask_next;
            rdy_reg <= rdy_next;
            wait_reg <= wait_next;
            cs_prev_reg <= level[0];
            seen_tgl_reg <= cs_rise ? level[1] : seen_tgl_reg;
        end
    end

    // readback word for the next frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rb_word_reg <= '0;
        end else if (exec && cmd == DRS_READ_WIPER) begin
            rb_word_reg <= {{(DW - WW){1'b0}}, wiper_reg[addr[0]]};
        end else if (state_reg == DRS_S_RDST) begin
            rb_word_reg <= rdata;
        end
    end
    assign rdy = rdy_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_exec_cs_high: assert property (exec |-> level[0] && !$past(level[0]))
        else $error("command executed without chip select rising");
    a_write_wiper0: assert property (exec && cmd == DRS_WRITE && !wp && !addr[0]
        |=> wiper0 == $past(data[WW-1:0]))
        else $error("write did not load wiper 0 from data bits 0..9");
    a_step_up_one: assert property (exec && cmd == DRS_UP_ONE && !wp && !addr[0] && wiper0 != FULL
        |=> wiper0 == $past(wiper0) + 10'h001)
        else $error("step up did not move wiper 0 by one");
    a_step_down_sat: assert property (exec && cmd == DRS_DOWN_ONE && !addr[0] && wiper0 == '0
        |=> wiper0 == '0)
        else $error("step down from zero did not hold at zero");
    a_double_full: assert property (exec && cmd == DRS_DOUBLE_ONE && !wp && !addr[0] && wiper0 >= MID
        |=> wiper0 == FULL)
        else $error("doubling from midscale did not reach full scale");
    a_halve_shift: assert property (exec && cmd == DRS_HALVE_ONE && !wp && addr[0]
        |=> wiper1 == ($past(wiper1) >> 1))
        else $error("halving did not shift wiper 1 right");
    a_gang_both: assert property (exec && cmd == DRS_DOWN_ALL && !wp && wiper0 != '0 && wiper1 != '0
        |=> wiper0 == $past(wiper0) - 10'h001 && wiper1 == $past(wiper1) - 10'h001)
        else $error("gang step did not move both wipers");
    a_save_busy: assert property (store_we |=> !rdy [*8])
        else $error("ready did not stay low after a save");
    a_rdy_kept: assert property (exec && rdy && (cmd == DRS_WRITE || cmd == DRS_UP_ALL || cmd == DRS_RESTORE)
        |=> rdy)
        else $error("ready dropped for a quick command");
    a_preset_mid: assert property (preset_low |=> wiper0 == MID && wiper1 == MID)
        else $error("preset pin low did not force midscale");
    a_lock_save: assert property (state_reg == DRS_S_WAIT && !preset_low
        |=> $stable(wiper0) && $stable(wiper1))
        else $error("wiper changed while locked");
    a_wp_block: assert property (exec && wp && cmd == DRS_WRITE |=> $stable(wiper0) && $stable(wiper1))
        else $error("write protect did not block a wiper write");
endmodule
`default_nettype wire

// ===== bench/drs_host.sv
// host model: serial master that frames bits for the rheostat core
`timescale 1ns/100ps
`default_nettype none
module drs_host (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // msb-first frame on a 64 ns link clock that only runs inside frames
    // chip select rises after the last falling edge of the link clock
    task automatic xfer(input logic [23:0] f, input int nb, output logic [23:0] rx);
        #7;
        cs_n = 1'b0;
        for (int i = 23; i > 23 - nb; i--) begin
            sdi = f[i];
            #32;
            rx = {rx[22:0], sdo};
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
        end
        #32;
        cs_n = 1'b1;
        // idle data line flips so a stale bit is never mistaken for a live one
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_drs_core.sv
// self-checking bench for the dual rheostat serial command core
`timescale 1ns/100ps
`default_nettype none
`include "drs_params.svh"
module tb_drs_core;
    import drs_pkg::*;
    // save kept longer than a frame so a frame can land inside it
    localparam int SV = 400;
    localparam int RS = 20;
    localparam int RD = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic preset_pin_n = 1'b1;
    logic wp_n = 1'b1;
    wire logic sclk, cs_n, sdi, sdo, rdy;
    wire logic [9:0] wiper0, wiper1;
    logic [31:0] seed = 32'hd4ede1ac;
    logic [31:0] r;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] lo = 32'h0;
    logic [23:0] rx_l;
    logic [23:0] prv;
    logic [23:0] lastf = 24'h0;
    logic [9:0] ew [2] = '{10'h200, 10'h200};
    logic [9:0] sv [2] = '{10'h200, 10'h200};
    logic [3:0] cmds [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    logic [23:0] corner [11] = '{24'hb0fc55, 24'hb00000, 24'h60abcd, 24'hc00000, 24'hb103ff,
        24'he10000, 24'hb00200, 24'hd00000, 24'hb001ff, 24'hc0ffff, 24'h407777};

    drs_core #(.SAVE_CYC(SV), .RESTORE_CYC(RS), .READ_CYC(RD)) drs_core_inst (.clk(clk), .rst_n(rst_n),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .preset_pin_n(preset_pin_n), .wp_n(wp_n), .sdo(sdo),
        .rdy(rdy), .wiper0(wiper0), .wiper1(wiper1));
    drs_host drs_host_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    always #10 clk = ~clk;
    // counted at the falling edge, clear of the edge that launches ready
    always @(negedge clk) begin
        cyc++;
        if (rdy === 1'b0)
            lo++;
        if (cyc == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [9:0] calc(input logic [3:0] c, input logic [9:0] w);
        case (c)
            DRS_HALVE_ONE, DRS_HALVE_ALL: return w >> 1;
            DRS_DOWN_ONE, DRS_DOWN_ALL: return (w == 10'h0) ? w : w - 10'h1;
            DRS_DOUBLE_ONE, DRS_DOUBLE_ALL: return (w == 10'h0) ? 10'h1 : (w >= 10'h200) ? 10'h3ff : w << 1;
            default: return (w == 10'h3ff) ? w : w + 10'h1;
        endcase
    endfunction
    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_w();
        check("wiper0", {14'h0, wiper0}, {14'h0, ew[0]});
        check("wiper1", {14'h0, wiper1}, {14'h0, ew[1]});
    endtask
    task automatic send(input logic [23:0] f, input int nb);
        @(negedge clk);
        lo = 0;
        prv = lastf;
        lastf = f;
        drs_host_inst.xfer(f, nb, rx_l);
    endtask
    task automatic settle();
        repeat (12) @(posedge clk);
        for (int k = 0; k < 600 && rdy !== 1'b1; k++)
            @(posedge clk);
        @(negedge clk);
    endtask
    task automatic op(input logic [23:0] f);
        send(f, 24);
        settle();
    endtask
    task automatic dur(input int n);
        check("busy time", {23'h0, lo >= n && lo <= n + 2}, 24'h1);
    endtask
    task automatic do_op(input logic [23:0] f);
        logic [3:0] c;
        c = f[23:20];
        op(f);
        check("echo", rx_l, prv);
        check("rdy low", lo[23:0], 24'h0);
        for (int ch = 0; ch < 2; ch++)
            if (ch == f[16] || (c[0] && c != DRS_WRITE))
                ew[ch] = (c == DRS_WRITE) ? f[9:0] : calc(c, ew[ch]);
        chk_w();
    endtask
    task automatic rd_st(input logic [3:0] a, input logic [15:0] e);
        op({DRS_READ_STORE, a, 16'h0});
        dur(RD);
        op(24'h0);
        check("store", {8'h0, rx_l[15:0]}, {8'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        chk_w();
        op(24'h0);
        foreach (corner[i])
            do_op(corner[i]);
        for (int i = 0; i < 80; i++) begin
            r = rnd();
            do_op({cmds[r[23:16] % 9], 3'h0, r[24], r[15:0]});
        end
        op({DRS_READ_WIPER, 4'h1, 16'hffff});
        dur(RD);
        op(24'h0);
        check("readback", rx_l, {8'ha1, 6'h0, ew[1]});
        r = rnd();
        op({DRS_SAVE_USER, 4'h5, r[15:0]});
        dur(SV);
        rd_st(4'h5, r[15:0]);
        op({DRS_SAVE_USER, `DRS_TOL_ADDR, r[15:0]});
        rd_st(`DRS_TOL_ADDR, `DRS_TOL_VALUE);
        op({DRS_SAVE_USER, 4'h0, r[31:16]});
        op({DRS_RESTORE, 4'h0, 16'h0});
        sv[0] = r[25:16];
        ew[0] = sv[0];
        chk_w();
        op({DRS_WRITE, 4'h1, r[15:0]});
        ew[1] = r[9:0];
        sv[1] = ew[1];
        send({DRS_SAVE, 4'h1, 16'h0}, 24);
        repeat (12) @(posedge clk);
        op({DRS_WRITE, 4'h1, ~r[15:0]});
        chk_w();
        op({DRS_WRITE, 4'h1, ~r[15:0]});
        op({DRS_RESTORE, 4'h1, 16'h0});
        chk_w();
        // wiper 0 moved off its stored value so the later restore-all shows
        op({DRS_WRITE, 4'h0, ~r[31:16]});
        ew[0] = ~r[25:16];
        wp_n = 1'b0;
        // a blocked write must differ from the value it fails to replace
        op({DRS_WRITE, 4'h1, ~r[15:0]});
        op({DRS_UP_ALL, 4'h0, 16'h0});
        chk_w();
        op({DRS_RESTORE_ALL, 4'h0, 16'h0});
        dur(RS);
        ew = sv;
        chk_w();
        wp_n = 1'b1;
        op({DRS_WRITE, 4'h1, 16'h0});
        preset_pin_n = 1'b0;
        repeat (10) @(negedge clk);
        ew = '{`DRS_MIDSCALE, `DRS_MIDSCALE};
        chk_w();
        check("rdy", {23'h0, rdy}, 24'h0);
        preset_pin_n = 1'b1;
        settle();
        ew = sv;
        chk_w();
        send({DRS_WRITE, 4'h0, 16'h0}, 16);
        settle();
        chk_w();
        report_and_stop();
    end
endmodule
`default_nettype wire
